// [pas_core.sv]
// digital side of a 12-bit pipelined sampling converter
// assumes front-end codes on clk; sample clock, gain and strap are pins
`timescale 1ns/1ps
`include "pas_regs.svh"

// Functional notes
// RULE1 - each sample clock rise starts a conversion, both inputs taken together
// RULE2 - result reaches outputs after two more starts plus conversion time
// RULE3 - capture logic latches each result on the third following rise
// RULE4 - result is a 12-bit two's complement word, top bit is sign
// RULE5 - overflow flag high exactly when word is most positive or negative
// RULE6 - gain pin high gives unity gain, low gives double gain
// RULE7 - clock source keeps sample clock above 20 kHz for accuracy
// RULE8 - internal timer refreshes dynamic logic after 1 ms without edge
// RULE9 - strap picks 4.096 V, 2.048 V, or external reference, amp off
// RULE10 - clock source never exceeds 5 Msps
// RULE11 - data word and overflow flag change together and hold until next
module pas_core import pas_pkg::*; #(
    parameter int REFRESH_CYC = `PAS_REFRESH_CYC
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // pins from the capture side and board straps
    input  wire logic               sample_clk_pin,
    input  wire logic               gain_sel_pin,
    input  wire logic [1:0]         ref_strap_pin,
    // quantiser front end, one code per input
    input  wire logic signed [11:0] ain_pos,
    input  wire logic signed [11:0] ain_neg,
    // result port
    output logic [11:0]             sample_data_bus,
    output logic                    overflow_flag,
    // housekeeping
    output logic                    refresh_pulse,
    output logic [15:0]             ref_millivolts,
    output logic                    ref_amp_enable,
    output logic                    pga_double_gain
);

    localparam int CONV_CYC_I = `PAS_CONV_CYC;
    // edges from a pin rise to the edge that takes its start; this lag
    // already counts toward the conversion time, so only the rest is waited
    localparam int SYNC_LAG   = 4;
    localparam int WAIT_CYC   = (CONV_CYC_I > SYNC_LAG) ?
                                (CONV_CYC_I - SYNC_LAG) : 0;

    // ==========================================================
    // elaboration checks
    generate
        if (REFRESH_CYC < 2 || REFRESH_CYC > 65535) begin : g_bad_ref
            $error("REFRESH_CYC must lie in 2..65535");
        end
        if (CONV_CYC_I < 1 || WAIT_CYC > 7) begin : g_bad_conv
            $error("conversion count must fit three bits");
        end
    endgenerate

    // ==========================================================
    // pin synchronisation
    logic [3:0] pins_sync;

    pas_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk  (clk),
        .rst  (rst),
        .din  ({ref_strap_pin, gain_sel_pin, sample_clk_pin}),
        .dout (pins_sync)
    );

    logic       sclk;
    logic       gain_unity;
    logic [1:0] strap;
    assign sclk       = pins_sync[0];
    assign gain_unity = pins_sync[1];
    assign strap      = pins_sync[3:2];

    // ==========================================================
    // sampling and scaling
    pas_core_state_t    st;
    pas_core_state_t    next_st;
    logic               start;
    logic               commit;
    logic               commit_now;
    logic signed [12:0] diff;
    logic signed [13:0] scaled;
    pas_result_t        sample_word;

    assign start = sclk & ~st.sclk_prev;                      // [RULE1]

    // both inputs are taken in the same cycle, so skew cannot creep in
    assign diff = 13'(ain_pos) - 13'(ain_neg);                // [RULE1]

    always_comb begin
        // double gain halves the span; unity keeps it
        if (gain_unity) begin
            scaled = 14'(diff);                               // [RULE6]
        end else begin
            scaled = {diff, 1'b0};                            // [RULE6]
        end
        // saturate into the 12-bit signed range
        if (scaled > 14'sh07FF) begin
            sample_word.data = `PAS_CODE_MAX;                 // [RULE4]
        end else if (scaled < -14'sh0800) begin
            sample_word.data = `PAS_CODE_MIN;                 // [RULE4]
        end else begin
            sample_word.data = scaled[11:0];                  // [RULE4]
        end
        sample_word.ovf = (sample_word.data == `PAS_CODE_MAX) ||
                          (sample_word.data == `PAS_CODE_MIN); // [RULE5]
    end

    // ==========================================================
    // pipeline, conversion timer, refresh timer, strap capture
    // with no wait left, the word of two starts back leaves on the start
    // edge, so it stands before the next rise even at the fastest rate
    assign commit_now = start && (WAIT_CYC == 0);             // [RULE2]
    // a start during a pending conversion flushes it first, so a fast
    // clock loses no result at the cost of a shorter settle time
    assign commit = commit_now || (st.conv_cnt == 3'h1) ||
                    (start && st.conv_cnt != 3'h0);

    always_comb begin
        next_st           = st;
        next_st.sclk_prev = sclk;
        next_st.refresh   = 1'b0;
        if (commit) begin
            next_st.out = commit_now ? st.stage1 : st.conv_word; // [RULE11]
        end
        if (st.conv_cnt != 3'h0) begin
            next_st.conv_cnt = st.conv_cnt - 3'h1;            // [RULE2]
        end
        if (start) begin
            next_st.stage0    = sample_word;                  // [RULE1]
            next_st.stage1    = st.stage0;                    // [RULE2]
            next_st.conv_word = st.stage1;                    // [RULE2]
            next_st.conv_cnt  = 3'(WAIT_CYC);                 // [RULE2]
            next_st.idle_cnt  = 16'h0000;                     // [RULE8]
        end else if (st.idle_cnt == 16'(REFRESH_CYC - 1)) begin
            next_st.idle_cnt = 16'h0000;                      // [RULE8]
            next_st.refresh  = 1'b1;                          // [RULE8]
        end else begin
            next_st.idle_cnt = st.idle_cnt + 16'h0001;
        end
        // strap is static; take it once the synchroniser has settled
        if (!st.strap_done) begin
            if (st.strap_wait == `PAS_STRAP_SETTLE) begin
                next_st.strap_done = 1'b1;                    // [RULE9]
                if (strap == 2'h0) begin
                    next_st.ref_sel = PAS_REF_GND;            // [RULE9]
                end else if (strap == 2'h1) begin
                    next_st.ref_sel = PAS_REF_VREF;           // [RULE9]
                end else begin
                    next_st.ref_sel = PAS_REF_VDD;            // [RULE9]
                end
            end else begin
                next_st.strap_wait = st.strap_wait + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st         <= '0;
            st.ref_sel <= PAS_REF_VDD;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs
    assign sample_data_bus = st.out.data;                     // [RULE4]
    assign overflow_flag   = st.out.ovf;                      // [RULE5]
    assign refresh_pulse   = st.refresh;
    assign pga_double_gain = ~gain_unity;                     // [RULE6]
    assign ref_amp_enable  = st.strap_done &&
                             (st.ref_sel != PAS_REF_VDD);     // [RULE9]
    assign ref_millivolts  = !st.strap_done ? `PAS_REF_EXT_MV :
                             (st.ref_sel == PAS_REF_GND)  ? `PAS_REF_HI_MV :
                             (st.ref_sel == PAS_REF_VREF) ? `PAS_REF_LO_MV :
                                                            `PAS_REF_EXT_MV;

    // ==========================================================
    // assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_start;
        start;
    endsequence

    sequence s_commit_due;
        !start && st.conv_cnt == 3'h1;
    endsequence

    AST_START_CAPTURE: assert property ( // [RULE1]
        s_start |=> (st.stage0 == $past(sample_word)))
        else $error("start did not capture the sample");

    AST_LATENCY: assert property ( // [RULE2]
        s_start |=> (WAIT_CYC != 0) || (st.out == $past(st.stage1)))
        else $error("result of two starts back not committed");

    AST_TIMED_COMMIT: assert property ( // [RULE2]
        s_commit_due |=>
            (st.conv_cnt == 3'h0) && (st.out == $past(st.conv_word)))
        else $error("result not committed after conversion time");

    AST_HOLD: assert property ( // [RULE11]
        !commit |=> $stable(st.out))
        else $error("outputs changed without a commit");

    AST_SIGN: assert property ( // [RULE4]
        s_start |=> (st.stage0.data[11] == $past(scaled[13])))
        else $error("sign bit does not follow the input");

    AST_OVF: assert property ( // [RULE5]
        overflow_flag == ((sample_data_bus == `PAS_CODE_MAX) ||
                          (sample_data_bus == `PAS_CODE_MIN)))
        else $error("overflow flag disagrees with the word");

    AST_GAIN_DOUBLE: assert property ( // [RULE6]
        (s_start and
            (!gain_unity && diff < 13'sh0200 && diff > -13'sh0200))
            |=> (st.stage0.data == $past(12'(diff << 1))))
        else $error("double gain not applied");

    AST_REFRESH: assert property ( // [RULE8]
        (!start && st.idle_cnt == 16'(REFRESH_CYC - 1)) |=>
            refresh_pulse ##1 !refresh_pulse)
        else $error("refresh pulse missing after idle time");

    AST_REF_SEL: assert property ( // [RULE9]
        $rose(st.strap_done) |->
            (ref_amp_enable == (st.ref_sel != PAS_REF_VDD)) &&
            ($past(strap) != 2'h0 || ref_millivolts == `PAS_REF_HI_MV))
        else $error("reference selection does not match strap");

endmodule : pas_core

// [pas_regs.svh]
// timing counts and strap values for the pipelined sample port
// assumes a 25 MHz core clock; included by bare name
`ifndef PAS_REGS_SVH
`define PAS_REGS_SVH

`define PAS_CLK_PERIOD_NS   40
`define PAS_CONV_TIME_NS    150
// least time: round up to whole cycles
`define PAS_CONV_CYC \
    ((`PAS_CONV_TIME_NS + `PAS_CLK_PERIOD_NS - 1) / `PAS_CLK_PERIOD_NS)
`define PAS_REFRESH_TIME_US 1000
`define PAS_REFRESH_CYC \
    ((`PAS_REFRESH_TIME_US * 1000) / `PAS_CLK_PERIOD_NS)
// the pin filter needs four edges before the strap level is valid
`define PAS_STRAP_SETTLE    3'h4
`define PAS_REF_HI_MV       16'h1000
`define PAS_REF_LO_MV       16'h0800
`define PAS_REF_EXT_MV      16'h0000
`define PAS_CODE_MAX        12'h7FF
`define PAS_CODE_MIN        12'h800

`endif

// [pas_pkg.sv]
// types shared by the pipelined sample port
// assumes nothing beyond the timing header
package pas_pkg;

    typedef struct packed {
        logic [11:0] data;
        logic        ovf;
    } pas_result_t;

    typedef enum logic [1:0] {
        PAS_REF_GND,
        PAS_REF_VREF,
        PAS_REF_VDD
    } pas_ref_sel_t;

    typedef struct packed {
        logic         sclk_prev;
        pas_result_t  stage0;
        pas_result_t  stage1;
        pas_result_t  conv_word;
        pas_result_t  out;
        logic [2:0]   conv_cnt;
        logic [15:0]  idle_cnt;
        logic         refresh;
        logic [2:0]   strap_wait;
        logic         strap_done;
        pas_ref_sel_t ref_sel;
    } pas_core_state_t;

endpackage : pas_pkg

// [pas_sync.sv]
// three-stage pin synchroniser with agreement filter
// assumes asynchronous pins; output moves once stages two and three agree
`timescale 1ns/1ps

module pas_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // pins and filtered levels
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] ff1;
        logic [WIDTH-1:0] ff2;
        logic [WIDTH-1:0] ff3;
        logic [WIDTH-1:0] lvl;
    } pas_sync_state_t;

    pas_sync_state_t  st;
    pas_sync_state_t  next_st;
    logic [WIDTH-1:0] next_lvl;

    generate
        if (WIDTH < 1) begin : g_bad
            $error("pas_sync needs a width of at least one");
        end
    endgenerate

    // ff1 is read only by ff2
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            assign next_lvl[i] = (st.ff2[i] == st.ff3[i]) ? st.ff3[i]
                                                          : st.lvl[i];
        end
    endgenerate

    always_comb begin
        next_st     = st;
        next_st.ff1 = din;
        next_st.ff2 = st.ff1;
        next_st.ff3 = st.ff2;
        next_st.lvl = next_lvl;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.lvl;

endmodule : pas_sync

// [pas_host.sv]
// capture-side partner: makes the sample clock and latches results
// assumes negedge-driven stimulus; pin stands low while run is low
`timescale 1ns/1ps

module pas_host import pas_pkg::*; (
    // clock and pacing
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic [7:0]  hi_cyc,
    input  wire logic [7:0]  lo_cyc,
    // converter side
    output logic             sample_clk_pin,
    input  wire logic [11:0] sample_data_bus,
    input  wire logic        overflow_flag,
    output pas_result_t      cap
);
    logic [7:0] cnt;

    initial begin
        sample_clk_pin = 1'b0;
        cnt = 8'h00;
        cap = '0;
    end

    // ==========================================================
    // pacing: phases of at least 3 clk keep within rate limits
    always @(negedge clk) begin
        if (!run) begin
            sample_clk_pin <= 1'b0;
            cnt <= 8'h00;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end else begin
            sample_clk_pin <= !sample_clk_pin;
            cnt <= (sample_clk_pin ? lo_cyc : hi_cyc) - 8'h01;
        end
    end

    // ==========================================================
    // capture on each rise; holds the result of three rises back
    always @(posedge sample_clk_pin) begin
        cap <= {sample_data_bus, overflow_flag};
    end
endmodule : pas_host

// [pipelined_adc_sample_port_test.sv]
// self-checking bench for the pipelined sample port core
// assumes small refresh count of 20 cycles; partner drives the pin
`timescale 1ns/1ps

module pipelined_adc_sample_port_test;
    import pas_pkg::*;
    logic               clk, rst, run, gain_sel_pin, sample_clk_pin;
    logic [7:0]         hi, lo;
    logic [1:0]         ref_strap_pin;
    logic signed [11:0] ain_pos, ain_neg;
    logic [11:0]        sample_data_bus;
    logic               overflow_flag, refresh_pulse;
    logic [15:0]        ref_millivolts;
    logic               ref_amp_enable, pga_double_gain;
    pas_result_t        cap;
    int                 fails, n_checks, n_ref;
    int tp[8] = '{100, 0, 2047, -2048, 2047, -2048, 1023, -5};
    int tn[8] = '{0, 100, -2048, 2047, 0, 0, 0, 3};

    pas_core #(.REFRESH_CYC(20)) i_dut (.clk(clk), .rst(rst),
        .sample_clk_pin(sample_clk_pin), .gain_sel_pin(gain_sel_pin),
        .ref_strap_pin(ref_strap_pin), .ain_pos(ain_pos),
        .ain_neg(ain_neg), .sample_data_bus(sample_data_bus),
        .overflow_flag(overflow_flag), .refresh_pulse(refresh_pulse),
        .ref_millivolts(ref_millivolts), .ref_amp_enable(ref_amp_enable),
        .pga_double_gain(pga_double_gain));
    pas_host i_host (.clk(clk), .run(run), .hi_cyc(hi), .lo_cyc(lo),
        .sample_clk_pin(sample_clk_pin), .sample_data_bus(sample_data_bus),
        .overflow_flag(overflow_flag), .cap(cap));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) if (refresh_pulse === 1'b1) n_ref++;

    // ==========================================================
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic stop_test;
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test

    // saturated difference, doubled when gain is low; flag at the ends
    function automatic logic [15:0] expv(input int p, input int n,
                                         input logic g);
        int d;
        logic [11:0] w;
        d = g ? p - n : 2 * (p - n);
        if (d > 2047) d = 2047;
        if (d < -2048) d = -2048;
        w = d[11:0];
        return {3'h0, w, (w == 12'hFFF >> 1) || (w == 12'h800)};
    endfunction : expv

    // ==========================================================
    task automatic t_strap;
        for (int s = 0; s < 4; s++) begin
            ref_strap_pin = s[1:0];
            rst = 1'b1;
            repeat (2) @(negedge clk);
            rst = 1'b0;
            repeat (8) @(negedge clk);
            chk(ref_millivolts, s == 0 ? 16'h1000 : s == 1 ? 16'h0800
                : 16'h0000);
            chk(16'(ref_amp_enable), 16'(s < 2));
        end
    endtask : t_strap

    task automatic t_stream(input logic g, input logic [7:0] h,
                            input logic [7:0] l);
        int nr;
        gain_sel_pin = g;
        repeat (8) @(negedge clk);
        chk(16'(pga_double_gain), 16'(!g));
        nr = 0;
        hi <= h;
        lo <= l;
        run <= 1'b1;
        for (int k = 0; k < 11; k++) begin
            @(posedge sample_clk_pin);
            // count from the second rise: starts then keep the timer reset
            if (k == 1)
                nr = n_ref;
            ain_pos = 12'(tp[k % 8]);
            ain_neg = 12'(tn[k % 8]);
            #1;
            if (k >= 3)
                chk(16'(cap), expv(tp[(k-3) % 8], tn[(k-3) % 8], g));
        end
        @(negedge sample_clk_pin);
        run <= 1'b0;
        chk(16'(n_ref), 16'(nr));
    endtask : t_stream

    // idle clock: pulses one cycle wide, 20 cycles apart, data held
    task automatic t_refresh;
        logic [11:0] held;
        repeat (12) @(negedge clk);
        held = sample_data_bus;
        for (int i = 0; i < 40 && refresh_pulse !== 1'b1; i++)
            @(negedge clk);
        chk(16'(refresh_pulse), 16'h0001);
        @(negedge clk);
        chk(16'(refresh_pulse), 16'h0000);
        repeat (18) @(negedge clk);
        chk(16'(refresh_pulse), 16'h0000);
        @(negedge clk);
        chk(16'(refresh_pulse), 16'h0001);
        chk(16'(sample_data_bus), 16'(held));
    endtask : t_refresh

    // ==========================================================
    initial begin
        #(20000 * 40);
        fails++;
        stop_test;
    end

    initial begin
        rst = 1'b1;
        run = 1'b0;
        hi = 8'h03;
        lo = 8'h03;
        gain_sel_pin = 1'b1;
        ref_strap_pin = 2'h0;
        ain_pos = 12'h000;
        ain_neg = 12'h000;
        fails = 0;
        n_checks = 0;
        n_ref = 0;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_strap;
        t_stream(1'b1, 8'h03, 8'h03);
        t_refresh;
        t_stream(1'b0, 8'h0A, 8'h0A);
        t_stream(1'b0, 8'h03, 8'h03);
        stop_test;
    end
endmodule : pipelined_adc_sample_port_test
